// *** design/wide_stack_pkg.sv ***
// What this block does
// - Stack registers hold flag in MSB, segment in bits 1-3, address in 4-31.
// - A stack fault sets bit 0 (the flag) of the stack limit register.
// - After a pop, flag underflow when pointer is below base.
// - Most pushes store first, then flag overflow when pointer exceeds limit.
// - Save-frame and lower-segment calls check overflow before pushing anything.
// - Push adds two to the pointer, then writes at the new pointer.
// - Pop reads each doubleword and subtracts two per doubleword.
// - Plain pushes and pops leave the frame pointer alone.
// - Subroutine entry saves, exit reloads, the frame pointer.
// - Cross-segment calls and returns load all four registers from page zero.
// - Each register can be read or written; pointer adjustable by operand.
// - Top-of-stack accesses use the pointer without changing it.
// - Block transfers move the pointer by four or more.
// - Return block is six words: status, accumulators 0-3, carry/return address.
// - First block word carries status high half, argument count low half.
// - Last pushed word carries carry in bit 0, return address in 1-31.
// - Fifth pushed word is accumulator 3, or old frame pointer when saving.
// - Before loading a new segment, save registers to the old page zero.
// - Limit of all ones below sign disables overflow detection.
// - Base of sign bit only disables underflow detection.
package wide_stack_pkg;

  // ****************************************
  // Register layout
  // ****************************************
  localparam int          FLAG_BIT    = 31;
  localparam int          SEG_HI      = 30;
  localparam int          SEG_LO      = 28;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] LIMIT_OFF   = 32'h7fff_ffff;
  localparam logic [31:0] BASE_OFF    = 32'h8000_0000;

  // ****************************************
  // Stack stepping and return block
  // ****************************************
  localparam logic [31:0] DWORD_STEP   = 32'h0000_0002;
  localparam logic [3:0]  RB_WORDS     = 4'h6;
  localparam logic [3:0]  SAVE_WORDS   = 4'h5;
  localparam logic [2:0]  RB_FIRST_ACC = 3'h2;
  localparam logic [2:0]  RB_FP_SLOT   = 3'h5;
  localparam logic [2:0]  RB_PC_SLOT   = 3'h6;
  localparam logic [3:0]  FP_POP_SLOT  = 4'h1;

  // ****************************************
  // Page-zero save area
  // ****************************************
  localparam logic [27:0] PZ_OFFSET  = 28'h000_0020;
  localparam logic [3:0]  SEG_PHASES = 4'h8;
  localparam int          REG_COUNT  = 4;

  typedef enum logic [1:0] {
    SEL_BASE,
    SEL_LIMIT,
    SEL_POINTER,
    SEL_FRAME
  } reg_sel_t;

  typedef enum logic [3:0] {
    OP_READ_REG,
    OP_WRITE_REG,
    OP_ADJUST_SP,
    OP_PUSH,
    OP_POP,
    OP_READ_TOP,
    OP_WRITE_TOP,
    OP_PUSH_BLOCK,
    OP_SAVE_FRAME,
    OP_POP_BLOCK,
    OP_FRAME_RETURN,
    OP_SEG_CHANGE
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRECHECK,
    ST_MEM,
    ST_WAIT,
    ST_CHECK,
    ST_DONE
  } state_t;

endpackage : wide_stack_pkg

// *** design/rb_if.sv ***
`timescale 1ns/1ps
interface rb_if;
  logic [2:0]  index;
  logic        save;
  logic [31:0] fp;
  logic [31:0] acc;
  logic [15:0] processor_status_word;
  logic [15:0] args;
  logic        carry;
  logic [30:0] pc;
  logic [31:0] word;
  modport fmt  (input index, save, fp, acc, processor_status_word, args, carry, pc, output word);
  modport user (output index, save, fp, acc, processor_status_word, args, carry, pc, input word);
endinterface : rb_if

// *** design/rb_formatter.sv ***
`timescale 1ns/1ps
module rb_formatter (
  rb_if.fmt port
);
  // ****************************************
  // Return block word builder
  // ****************************************
  // Bit 0 is the most significant bit in the block layout
  always_comb begin
    if (port.index == 3'h1) begin
      port.word = {port.processor_status_word, port.args};
    end else if (port.index == wide_stack_pkg::RB_PC_SLOT) begin
      port.word = {port.carry, port.pc};
    end else if (port.index == wide_stack_pkg::RB_FP_SLOT && port.save) begin
      port.word = port.fp;
    end else begin
      port.word = port.acc;
    end
  end
endmodule : rb_formatter

// *** design/wide_stack_manager.sv ***
`timescale 1ns/1ps
module wide_stack_manager (
  input  wire logic                 REF_CLK,
  input  wire logic                 ARST_N,
  input  wire logic                 CMD_VALID,
  output      logic                 CMD_READY,
  input  wire wide_stack_pkg::op_t  CMD_OP,
  input  wire wide_stack_pkg::reg_sel_t CMD_SEL,
  input  wire logic [31:0]          CMD_OPERAND,
  input  wire logic [3:0]           CMD_COUNT,
  input  wire logic                 CMD_PRECHECK,
  input  wire logic [2:0]           CMD_SEG,
  output      logic                 CMD_DONE,
  output      logic [31:0]          CMD_RESULT,
  input  wire logic [31:0]          PUSH_DATA,
  output      logic                 PUSH_TAKE,
  output      logic [31:0]          POP_DATA,
  output      logic                 POP_VALID,
  input  wire logic [15:0]          RB_PSR,
  input  wire logic [15:0]          RB_ARGS,
  input  wire logic                 RB_CARRY,
  input  wire logic [30:0]          RB_PC,
  output      logic                 MEM_REQ,
  output      logic                 MEM_WE,
  output      logic [31:0]          MEM_ADDR,
  output      logic [31:0]          MEM_WDATA,
  input  wire logic [31:0]          MEM_RDATA,
  input  wire logic                 MEM_ACK,
  output      logic                 FAULT_OVERFLOW,
  output      logic                 FAULT_UNDERFLOW,
  output      logic [31:0]          STACK_BASE,
  output      logic [31:0]          STACK_LIMIT,
  output      logic [31:0]          STACK_POINTER,
  output      logic [31:0]          FRAME_POINTER
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    wide_stack_pkg::state_t st;
    wide_stack_pkg::op_t    op;
    logic [31:0]            base;
    logic [31:0]            limit;
    logic [31:0]            sp;
    logic [31:0]            fp;
    logic [31:0]            result;
    logic [31:0]            pop_data;
    logic [31:0]            mem_addr;
    logic [31:0]            mem_wdata;
    logic [3:0]             cnt;
    logic [3:0]             num;
    logic [2:0]             seg;
    logic [2:0]             seg_old;
    logic                   pre;
    logic                   mem_req;
    logic                   mem_we;
    logic                   ovf;
    logic                   unf;
    logic                   pop_valid;
    logic                   push_take;
    logic                   faulted;
  } core_t;

  core_t       s;
  core_t       next_s;
  logic        is_push;
  logic        is_pop;
  logic        is_top;
  logic [2:0]  rb_index;
  logic        uses_acc;
  logic [31:0] span;

  rb_if rb ();

  rb_formatter u_fmt (
    .port (rb.fmt)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] pick_reg(input core_t c, input logic [1:0] sel);
    logic [31:0] v;
    v = c.base;
    if (sel == 2'(wide_stack_pkg::SEL_LIMIT)) begin
      v = c.limit;
    end else if (sel == 2'(wide_stack_pkg::SEL_POINTER)) begin
      v = c.sp;
    end else if (sel == 2'(wide_stack_pkg::SEL_FRAME)) begin
      v = c.fp;
    end
    return v;
  endfunction : pick_reg

  function automatic core_t put_reg(input core_t c, input logic [1:0] sel,
                                    input logic [31:0] v);
    core_t r;
    r = c;
    if (sel == 2'(wide_stack_pkg::SEL_BASE)) begin
      r.base = v;
    end else if (sel == 2'(wide_stack_pkg::SEL_LIMIT)) begin
      r.limit = v;
    end else if (sel == 2'(wide_stack_pkg::SEL_POINTER)) begin
      r.sp = v;
    end else begin
      r.fp = v;
    end
    return r;
  endfunction : put_reg

  // Reserved save words of a segment, one doubleword per register
  function automatic logic [31:0] pz_addr(input logic [2:0] seg, input logic [1:0] idx);
    return {1'b0, seg, wide_stack_pkg::PZ_OFFSET + 28'({idx, 1'b0})};
  endfunction : pz_addr

  assign is_push = s.op inside {wide_stack_pkg::OP_PUSH, wide_stack_pkg::OP_PUSH_BLOCK,
                                wide_stack_pkg::OP_SAVE_FRAME};
  assign is_pop  = s.op inside {wide_stack_pkg::OP_POP, wide_stack_pkg::OP_POP_BLOCK,
                                wide_stack_pkg::OP_FRAME_RETURN};
  assign is_top  = s.op inside {wide_stack_pkg::OP_READ_TOP, wide_stack_pkg::OP_WRITE_TOP};
  assign rb_index = 3'(s.cnt + 4'h1);
  assign uses_acc = (rb_index >= wide_stack_pkg::RB_FIRST_ACC)
                  && (rb_index <= wide_stack_pkg::RB_FP_SLOT)
                  && !(s.op == wide_stack_pkg::OP_SAVE_FRAME
                       && rb_index == wide_stack_pkg::RB_FP_SLOT);
  // Room the whole block will take, for the early overflow check
  assign span = {27'h000_0000, s.num, 1'b0};

  assign rb.index = rb_index;
  assign rb.save  = (s.op == wide_stack_pkg::OP_SAVE_FRAME);
  assign rb.fp    = s.fp;
  assign rb.acc   = PUSH_DATA;
  assign rb.processor_status_word   = RB_PSR;
  assign rb.args  = RB_ARGS;
  assign rb.carry = RB_CARRY;
  assign rb.pc    = RB_PC;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.ovf = 1'b0;
    next_s.unf = 1'b0;
    next_s.pop_valid = 1'b0;
    next_s.push_take = 1'b0;
    case (s.st)
      wide_stack_pkg::ST_IDLE: begin
        if (CMD_VALID) begin
          next_s.op = CMD_OP;
          next_s.cnt = 4'h0;
          next_s.faulted = 1'b0;
          next_s.pre = CMD_PRECHECK;
          next_s.seg = CMD_SEG;
          next_s.seg_old = s.sp[wide_stack_pkg::SEG_HI:wide_stack_pkg::SEG_LO];
          next_s.num = CMD_COUNT;
          next_s.st = wide_stack_pkg::ST_MEM;
          case (CMD_OP)
            wide_stack_pkg::OP_READ_REG: begin
              next_s.result = pick_reg(s, CMD_SEL);
              next_s.st = wide_stack_pkg::ST_DONE;
            end
            wide_stack_pkg::OP_WRITE_REG: begin
              next_s = put_reg(next_s, CMD_SEL, CMD_OPERAND);
              next_s.st = wide_stack_pkg::ST_DONE;
            end
            wide_stack_pkg::OP_ADJUST_SP: begin
              next_s.sp = s.sp + CMD_OPERAND;
              next_s.st = wide_stack_pkg::ST_DONE;
            end
            wide_stack_pkg::OP_PUSH, wide_stack_pkg::OP_POP: begin
              if (CMD_COUNT == 4'h0) begin
                next_s.st = wide_stack_pkg::ST_DONE;
              end
            end
            wide_stack_pkg::OP_READ_TOP, wide_stack_pkg::OP_WRITE_TOP: begin
              next_s.num = 4'h1;
            end
            wide_stack_pkg::OP_PUSH_BLOCK: begin
              next_s.num = wide_stack_pkg::RB_WORDS;
              if (CMD_PRECHECK) begin
                next_s.st = wide_stack_pkg::ST_PRECHECK;
              end
            end
            wide_stack_pkg::OP_SAVE_FRAME: begin
              next_s.num = wide_stack_pkg::SAVE_WORDS;
              next_s.pre = 1'b1;
              next_s.st = wide_stack_pkg::ST_PRECHECK;
            end
            wide_stack_pkg::OP_POP_BLOCK: begin
              next_s.num = wide_stack_pkg::RB_WORDS;
            end
            wide_stack_pkg::OP_FRAME_RETURN: begin
              // Callee data above the frame is discarded before the block pops
              next_s.sp = s.fp;
              next_s.num = wide_stack_pkg::RB_WORDS;
            end
            default: begin
              next_s.num = wide_stack_pkg::SEG_PHASES;
            end
          endcase
        end
      end
      wide_stack_pkg::ST_PRECHECK: begin
        // Nothing is written when the block would not fit
        if ($signed(s.sp + span) > $signed(s.limit)) begin
          next_s.ovf = 1'b1;
          next_s.faulted = 1'b1;
          next_s.limit[wide_stack_pkg::FLAG_BIT] = 1'b1;
          next_s.st = wide_stack_pkg::ST_DONE;
        end else begin
          next_s.st = wide_stack_pkg::ST_MEM;
        end
      end
      wide_stack_pkg::ST_MEM: begin
        next_s.mem_req = 1'b1;
        next_s.st = wide_stack_pkg::ST_WAIT;
        if (is_push) begin
          next_s.sp = s.sp + wide_stack_pkg::DWORD_STEP;
          next_s.mem_addr = s.sp + wide_stack_pkg::DWORD_STEP;
          next_s.mem_we = 1'b1;
          next_s.mem_wdata = (s.op == wide_stack_pkg::OP_PUSH) ? PUSH_DATA : rb.word;
          // Take follows the capture, so the next word is offered before it is needed
          next_s.push_take = (s.op == wide_stack_pkg::OP_PUSH) || uses_acc;
        end else if (is_pop || is_top) begin
          next_s.mem_addr = s.sp;
          next_s.mem_we = (s.op == wide_stack_pkg::OP_WRITE_TOP);
          next_s.mem_wdata = CMD_OPERAND;
        end else if (s.cnt < 4'(wide_stack_pkg::REG_COUNT)) begin
          // Old segment is saved before anything is reloaded
          next_s.mem_addr = pz_addr(s.seg_old, s.cnt[1:0]);
          next_s.mem_we = 1'b1;
          next_s.mem_wdata = pick_reg(s, s.cnt[1:0]);
        end else begin
          next_s.mem_addr = pz_addr(s.seg, s.cnt[1:0]);
          next_s.mem_we = 1'b0;
        end
      end
      wide_stack_pkg::ST_WAIT: begin
        if (MEM_ACK) begin
          next_s.mem_req = 1'b0;
          next_s.mem_we = 1'b0;
          next_s.cnt = s.cnt + 4'h1;
          next_s.st = (s.cnt + 4'h1 == s.num) ? wide_stack_pkg::ST_CHECK
                                              : wide_stack_pkg::ST_MEM;
          if (is_pop) begin
            next_s.sp = s.sp - wide_stack_pkg::DWORD_STEP;
            next_s.pop_data = MEM_RDATA;
            next_s.pop_valid = 1'b1;
            if (s.op == wide_stack_pkg::OP_FRAME_RETURN && s.cnt == wide_stack_pkg::FP_POP_SLOT) begin
              next_s.fp = MEM_RDATA;
            end
          end else if (is_top) begin
            next_s.result = MEM_RDATA;
          end else if (!is_push && s.cnt >= 4'(wide_stack_pkg::REG_COUNT)) begin
            next_s = put_reg(next_s, s.cnt[1:0], MEM_RDATA);
          end
        end
      end
      wide_stack_pkg::ST_CHECK: begin
        next_s.st = wide_stack_pkg::ST_DONE;
        if (s.op == wide_stack_pkg::OP_SAVE_FRAME) begin
          next_s.fp = s.sp;
        end
        // Signed compare: the disable values sit at the extremes of the range
        if (is_push && !s.pre && !s.faulted && $signed(s.sp) > $signed(s.limit)) begin
          next_s.ovf = 1'b1;
          next_s.faulted = 1'b1;
          next_s.limit[wide_stack_pkg::FLAG_BIT] = 1'b1;
        end else if (is_pop && !s.faulted && $signed(s.sp) < $signed(s.base)) begin
          next_s.unf = 1'b1;
          next_s.faulted = 1'b1;
          next_s.limit[wide_stack_pkg::FLAG_BIT] = 1'b1;
        end
      end
      default: begin
        next_s.st = wide_stack_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign CMD_READY       = (s.st == wide_stack_pkg::ST_IDLE);
  assign CMD_DONE        = (s.st == wide_stack_pkg::ST_DONE);
  assign CMD_RESULT      = s.result;
  assign PUSH_TAKE       = s.push_take;
  assign POP_DATA        = s.pop_data;
  assign POP_VALID       = s.pop_valid;
  assign MEM_REQ         = s.mem_req;
  assign MEM_WE          = s.mem_we;
  assign MEM_ADDR        = s.mem_addr;
  assign MEM_WDATA       = s.mem_wdata;
  assign FAULT_OVERFLOW  = s.ovf;
  assign FAULT_UNDERFLOW = s.unf;
  assign STACK_BASE      = s.base;
  assign STACK_LIMIT     = s.limit;
  assign STACK_POINTER   = s.sp;
  assign FRAME_POINTER   = s.fp;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  chk_push_step: assert property (
    (s.st == wide_stack_pkg::ST_MEM && is_push)
      |=> (s.sp == $past(s.sp) + 32'h0000_0002) && (MEM_ADDR == s.sp) && MEM_WE)
    else $error("push did not step pointer by two before writing");
  chk_pop_step: assert property (
    (s.st == wide_stack_pkg::ST_WAIT && MEM_ACK && is_pop)
      |=> (s.sp == $past(s.sp) - 32'h0000_0002) && POP_VALID && POP_DATA == $past(MEM_RDATA))
    else $error("pop did not step pointer down by two");
  chk_frame_hold: assert property (
    (s.st != wide_stack_pkg::ST_IDLE
      && s.op inside {wide_stack_pkg::OP_PUSH, wide_stack_pkg::OP_POP})
      |=> $stable(FRAME_POINTER))
    else $error("frame pointer moved during plain push or pop");
  chk_fault_flag: assert property (
    (FAULT_OVERFLOW || FAULT_UNDERFLOW) |-> STACK_LIMIT[wide_stack_pkg::FLAG_BIT] && CMD_DONE)
    else $error("fault without limit flag");
  chk_post_overflow: assert property (
    (s.st == wide_stack_pkg::ST_CHECK && is_push && !s.pre && !s.faulted
      && $signed(s.sp) > $signed(s.limit)) |=> FAULT_OVERFLOW)
    else $error("overflow after push not reported");
  chk_pre_no_write: assert property (
    (s.st == wide_stack_pkg::ST_PRECHECK && $signed(s.sp + span) > $signed(s.limit))
      |=> FAULT_OVERFLOW && !MEM_REQ ##1 CMD_READY && !MEM_REQ)
    else $error("early overflow check let a push through");
  chk_underflow: assert property (
    (s.st == wide_stack_pkg::ST_CHECK && is_pop && !s.faulted
      && $signed(s.sp) < $signed(s.base)) |=> FAULT_UNDERFLOW)
    else $error("underflow after pop not reported");
  chk_top_keep: assert property (
    (s.st != wide_stack_pkg::ST_IDLE && is_top) |=> $stable(STACK_POINTER))
    else $error("top access moved the pointer");
  chk_one_fault: assert property (
    FAULT_OVERFLOW |=> !FAULT_OVERFLOW && !FAULT_UNDERFLOW)
    else $error("second fault in one operation");
  chk_seg_save_first: assert property (
    (s.st == wide_stack_pkg::ST_WAIT && s.op == wide_stack_pkg::OP_SEG_CHANGE
      && s.cnt < 4'(wide_stack_pkg::REG_COUNT))
      |-> MEM_WE && MEM_ADDR[wide_stack_pkg::SEG_HI:wide_stack_pkg::SEG_LO] == s.seg_old)
    else $error("segment change loaded before saving");
  chk_save_slot: assert property (
    (s.st == wide_stack_pkg::ST_MEM && s.op == wide_stack_pkg::OP_SAVE_FRAME
      && rb_index == wide_stack_pkg::RB_FP_SLOT) |=> MEM_WDATA == $past(s.fp))
    else $error("save block slot five lacks frame pointer");
  chk_status_word: assert property (
    (s.st == wide_stack_pkg::ST_MEM && is_push && s.op != wide_stack_pkg::OP_PUSH
      && rb_index == 3'h1)
      |=> MEM_WDATA == {$past(RB_PSR), $past(RB_ARGS)})
    else $error("first block word lacks status and argument count");
  cov_push_overflow: cover property (FAULT_OVERFLOW && s.op == wide_stack_pkg::OP_PUSH);
  cov_frame_return:  cover property (CMD_DONE && s.op == wide_stack_pkg::OP_FRAME_RETURN);
  cov_seg_change:    cover property (CMD_DONE && s.op == wide_stack_pkg::OP_SEG_CHANGE);
  cov_underflow:     cover property (FAULT_UNDERFLOW);

endmodule : wide_stack_manager

// *** verif/mem_model.sv ***
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  output      logic [31:0] rdata,
  output      logic        ack
);
  // ********
  // Memory side of the core
  // ********
  logic [31:0] mem [logic [31:0]];
  int          writes = 0;
  int          wait_n;
  // Read data flips every idle cycle so a late sample cannot pass by luck
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack    <= 1'b0;
      rdata  <= 32'h0;
      wait_n <= 0;
    end else if (req && !ack && wait_n >= (slow ? 3 : 0)) begin
      ack    <= 1'b1;
      wait_n <= 0;
      if (we) begin
        mem[addr] = wdata;
        writes    <= writes + 1;
      end else begin
        rdata <= mem.exists(addr) ? mem[addr] : ~rdata;
      end
    end else begin
      ack    <= 1'b0;
      rdata  <= ~rdata;
      wait_n <= req ? wait_n + 1 : 0;
    end
  end
endmodule : mem_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  // ********
  // Signals, design and partner
  // ********
  wide_stack_pkg::op_t      CMD_OP;
  wide_stack_pkg::reg_sel_t CMD_SEL;
  logic        REF_CLK, ARST_N, CMD_VALID, CMD_READY, CMD_PRECHECK, CMD_DONE, slow;
  logic        PUSH_TAKE, POP_VALID, RB_CARRY, MEM_REQ, MEM_WE, MEM_ACK, ovf, unf;
  logic        FAULT_OVERFLOW, FAULT_UNDERFLOW;
  logic [2:0]  CMD_SEG;
  logic [3:0]  CMD_COUNT;
  logic [15:0] RB_PSR, RB_ARGS;
  logic [30:0] RB_PC;
  logic [31:0] CMD_OPERAND, CMD_RESULT, PUSH_DATA, POP_DATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic [31:0] STACK_BASE, STACK_LIMIT, STACK_POINTER, FRAME_POINTER, res;
  int          err_total, n_compared, pidx, w0, n_pops;
  typedef struct {
    logic [3:0]  op;
    logic [1:0]  sel;
    logic [31:0] opnd;
    logic [3:0]  cnt;
    logic [31:0] sp;
    logic [31:0] fp;
    logic [31:0] res;
    logic        ovf;
    logic        unf;
  } row_t;
  // Columns: op code, register, operand, count, pointer, frame, read data, faults
  row_t rows [22] = '{
    '{4'h1, 2'h0, 32'h100, 4'h0, 32'h0, 32'h0, 32'h0, 1'b0, 1'b0},
    '{4'h1, 2'h1, 32'h120, 4'h0, 32'h0, 32'h0, 32'h0, 1'b0, 1'b0},
    '{4'h1, 2'h2, 32'h100, 4'h0, 32'h100, 32'h0, 32'h0, 1'b0, 1'b0},
    '{4'h1, 2'h3, 32'h100, 4'h0, 32'h100, 32'h100, 32'h0, 1'b0, 1'b0},
    '{4'h0, 2'h1, 32'h0, 4'h0, 32'h100, 32'h100, 32'h120, 1'b0, 1'b0},
    '{4'h0, 2'h3, 32'h0, 4'h0, 32'h100, 32'h100, 32'h100, 1'b0, 1'b0},
    '{4'h3, 2'h0, 32'h0, 4'h2, 32'h104, 32'h100, 32'h0, 1'b0, 1'b0},
    '{4'h4, 2'h0, 32'h0, 4'h1, 32'h102, 32'h100, 32'h0, 1'b0, 1'b0},
    '{4'h2, 2'h0, 32'h4, 4'h0, 32'h106, 32'h100, 32'h0, 1'b0, 1'b0},
    '{4'h6, 2'h0, 32'h5a5a, 4'h0, 32'h106, 32'h100, 32'h0, 1'b0, 1'b0},
    '{4'h5, 2'h0, 32'h0, 4'h0, 32'h106, 32'h100, 32'h5a5a, 1'b0, 1'b0},
    '{4'h0, 2'h2, 32'h0, 4'h0, 32'h106, 32'h100, 32'h106, 1'b0, 1'b0},
    '{4'h4, 2'h0, 32'h0, 4'h4, 32'hfe, 32'h100, 32'h0, 1'b0, 1'b1},
    '{4'h2, 2'h0, 32'h24, 4'h0, 32'h122, 32'h100, 32'h0, 1'b0, 1'b0},
    '{4'h3, 2'h0, 32'h0, 4'h1, 32'h124, 32'h100, 32'h0, 1'b1, 1'b0},
    '{4'h0, 2'h1, 32'h0, 4'h0, 32'h124, 32'h100, 32'h8000_0120, 1'b0, 1'b0},
    '{4'h1, 2'h1, 32'h7fff_ffff, 4'h0, 32'h124, 32'h100, 32'h0, 1'b0, 1'b0},
    '{4'h3, 2'h0, 32'h0, 4'h1, 32'h126, 32'h100, 32'h0, 1'b0, 1'b0},
    '{4'h1, 2'h0, 32'h8000_0000, 4'h0, 32'h126, 32'h100, 32'h0, 1'b0, 1'b0},
    '{4'h0, 2'h0, 32'h0, 4'h0, 32'h126, 32'h100, 32'h8000_0000, 1'b0, 1'b0},
    '{4'h1, 2'h2, 32'h2, 4'h0, 32'h2, 32'h100, 32'h0, 1'b0, 1'b0},
    '{4'h4, 2'h0, 32'h0, 4'h2, 32'hffff_fffe, 32'h100, 32'h0, 1'b0, 1'b0}
  };

  wide_stack_manager dut_u (.*);
  mem_model mm (.clk(REF_CLK), .rst_n(ARST_N), .slow(slow), .req(MEM_REQ), .we(MEM_WE),
                .addr(MEM_ADDR), .wdata(MEM_WDATA), .rdata(MEM_RDATA), .ack(MEM_ACK));

  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // Next accumulator word is offered just after each take
  always @(posedge REF_CLK) begin
    if (PUSH_TAKE === 1'b1) begin
      #1;
      pidx++;
    end
  end
  assign PUSH_DATA = 32'hac00_0000 + 32'(pidx);
  always @(posedge REF_CLK) begin
    if (POP_VALID === 1'b1) n_pops++;
  end
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Command fields stay put until done, as write-top reads its operand late
  task automatic run(input logic [3:0] op, input logic [1:0] sel, input logic [31:0] opnd,
                     input logic [3:0] cnt, input logic pre);
    int n;
    n = 0;
    CMD_OP = wide_stack_pkg::op_t'(op);
    CMD_SEL = wide_stack_pkg::reg_sel_t'(sel);
    CMD_OPERAND = opnd;
    CMD_COUNT = cnt;
    CMD_PRECHECK = pre;
    pidx = 0;
    CMD_VALID = 1'b1;
    @(posedge REF_CLK);
    #1;
    CMD_VALID = 1'b0;
    while (CMD_DONE !== 1'b1 && n < 100) begin
      @(posedge REF_CLK);
      #1;
      n++;
    end
    chk(32'(n < 100), 32'h1, "command done");
    ovf = FAULT_OVERFLOW;
    unf = FAULT_UNDERFLOW;
    res = CMD_RESULT;
    @(posedge REF_CLK);
    #1;
  endtask : run

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {ARST_N, CMD_VALID, CMD_PRECHECK, slow, err_total, n_compared, pidx, n_pops} = '0;
    CMD_OP = wide_stack_pkg::OP_READ_REG;
    CMD_SEL = wide_stack_pkg::SEL_BASE;
    {CMD_OPERAND, CMD_COUNT, CMD_SEG} = '0;
    {RB_PSR, RB_ARGS, RB_CARRY, RB_PC} = {16'h1234, 16'h0003, 1'b1, 31'h4000};
    repeat (2) @(posedge REF_CLK);
    #1;
    ARST_N = 1'b1;
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].sel, rows[i].opnd, rows[i].cnt, 1'b0);
      chk(STACK_POINTER, rows[i].sp, "pointer");
      chk(FRAME_POINTER, rows[i].fp, "frame");
      chk(32'(ovf), 32'(rows[i].ovf), "overflow");
      chk(32'(unf), 32'(rows[i].unf), "underflow");
      if (rows[i].op inside {4'h0, 4'h5}) chk(res, rows[i].res, "read");
      $display("row %0d done", i);
    end
    slow = 1'b1;
    run(4'h1, 2'h0, 32'h100, 4'h0, 1'b0);
    run(4'h1, 2'h1, 32'h200, 4'h0, 1'b0);
    run(4'h1, 2'h2, 32'h100, 4'h0, 1'b0);
    run(4'h7, 2'h0, 32'h0, 4'h6, 1'b0);
    chk(STACK_POINTER, 32'h10c, "block pointer");
    chk(mm.mem[32'h102], 32'h1234_0003, "status word");
    chk(mm.mem[32'h104], 32'hac00_0000, "acc 0");
    chk(mm.mem[32'h10a], 32'hac00_0003, "acc 3");
    chk(mm.mem[32'h10c], {1'b1, 31'h4000}, "carry and pc");
    run(4'h8, 2'h0, 32'h0, 4'h5, 1'b0);
    chk(mm.mem[32'h116], 32'h100, "saved frame");
    chk(FRAME_POINTER, 32'h116, "new frame");
    $display("return block done");
    run(4'h1, 2'h1, 32'h110, 4'h0, 1'b0);
    w0 = mm.writes;
    run(4'h7, 2'h0, 32'h0, 4'h6, 1'b1);
    chk(32'(ovf), 32'h1, "early overflow");
    chk(32'(mm.writes), 32'(w0), "nothing written");
    chk(STACK_POINTER, 32'h116, "pointer kept");
    mm.mem[32'h114] = 32'h100;
    run(4'ha, 2'h0, 32'h0, 4'h6, 1'b0);
    chk(STACK_POINTER, 32'h10a, "return pointer");
    chk(FRAME_POINTER, 32'h100, "return frame");
    chk(POP_DATA, 32'h8000_4000, "last popped");
    w0 = n_pops;
    run(4'h9, 2'h0, 32'h0, 4'h6, 1'b0);
    chk(32'(n_pops - w0), 32'h6, "pops seen");
    chk(STACK_POINTER, 32'hfe, "block pop pointer");
    chk(32'(unf), 32'h1, "block underflow");
    $display("precheck and return done");
    for (int i = 0; i < 4; i++) mm.mem[{4'h2, 28'h20 + 28'(2 * i)}] = 32'h2000_0400 + 32'(i);
    CMD_SEG = 3'h2;
    run(4'hb, 2'h0, 32'h0, 4'h0, 1'b0);
    chk(mm.mem[32'h20], 32'h100, "saved base");
    chk(mm.mem[32'h22], 32'h8000_0110, "saved limit");
    chk(mm.mem[32'h24], 32'hfe, "saved pointer");
    chk(STACK_BASE, 32'h2000_0400, "new base");
    chk(STACK_LIMIT, 32'h2000_0401, "new limit");
    chk(FRAME_POINTER, 32'h2000_0403, "new frame");
    $display("segment change done");
    ARST_N = 1'b0;
    #1;
    chk(STACK_POINTER, 32'h0, "pointer in reset");
    chk(32'(CMD_READY), 32'h1, "ready in reset");
    $display("reset done");
    give_verdict();
  end
endmodule : tb
